// ---- src/fws_pkg.sv ----
`default_nettype none
package fws_pkg;
    localparam int DQ_W      = 16;
    localparam int APB_AW    = 8;
    localparam int CLK_NS    = 5;

    localparam logic [APB_AW-1:0] OFF_CTRL  = 8'h00;
    localparam logic [APB_AW-1:0] OFF_ADDR  = 8'h04;
    localparam logic [APB_AW-1:0] OFF_DATA  = 8'h08;
    localparam logic [APB_AW-1:0] OFF_STAT  = 8'h0c;
    localparam logic [APB_AW-1:0] OFF_RDATA = 8'h10;

    localparam int CTRL_START = 0;
    localparam int CTRL_OP_LO = 1;
    localparam int CTRL_OP_HI = 2;

    localparam int STAT_BUSY = 0;
    localparam int STAT_DONE = 1;
    localparam int STAT_FAIL = 2;
    localparam int STAT_RDY  = 3;
    localparam int STAT_TOG  = 4;
    localparam int STAT_STOG = 5;
    localparam int STAT_TMO  = 6;

    localparam int POLL_BIT = 7;
    localparam int TOG_BIT  = 6;
    localparam int TMO_BIT  = 5;
    localparam int STOG_BIT = 2;

    localparam logic [DQ_W-1:0] RESET_CMD = 16'h00f0;

    localparam int SYNC_STAGES = 3;
    localparam int T_ACC_NS    = 70;
    localparam int T_WP_NS     = 35;
    localparam int T_GAP_NS    = 20;

    localparam logic [15:0] ACC_CYC = 16'((T_ACC_NS + CLK_NS - 1) / CLK_NS + SYNC_STAGES);
    localparam logic [15:0] WP_CYC  = 16'((T_WP_NS + CLK_NS - 1) / CLK_NS);
    localparam logic [15:0] GAP_CYC = 16'((T_GAP_NS + CLK_NS - 1) / CLK_NS);

    typedef enum logic [1:0] {
        OP_WRITE = 2'h0,
        OP_DPOLL = 2'h1,
        OP_TPOLL = 2'h2,
        OP_RESET = 2'h3
    } fws_op_t;

    typedef enum logic [7:0] {
        ST_IDLE  = 8'h01,
        ST_START = 8'h02,
        ST_RDACT = 8'h04,
        ST_RDGAP = 8'h08,
        ST_WRACT = 8'h10,
        ST_WRGAP = 8'h20,
        ST_EVAL  = 8'h40,
        ST_TOR   = 8'h80
    } fws_state_t;
endpackage
`default_nettype wire

// ---- src/fws_sync.sv ----
`default_nettype none
module fws_sync #(
    parameter int W = 1
) (
    input  wire logic         core_clk,
    input  wire logic         rstn,
    input  wire logic         ce,
    input  wire logic [W-1:0] d,
    output logic      [W-1:0] q
);
    typedef struct packed {
        logic [W-1:0] s1;
        logic [W-1:0] s2;
        logic [W-1:0] s3;
        logic [W-1:0] q;
    } fws_sync_t;

    fws_sync_t r;
    fws_sync_t next_r;

    // a bit only moves once stages two and three agree
    always_comb begin
        next_r    = r;
        next_r.s1 = d;
        next_r.s2 = r.s1;
        next_r.s3 = r.s2;
        next_r.q  = (r.s2 & r.s3) | (r.q & (r.s2 ^ r.s3));
    end

    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            r <= '0;
        end else if (ce) begin
            r <= next_r;
        end
    end

    assign q = r.q;
endmodule
`default_nettype wire

// ---- src/fws_host.sv ----
// Behaviour
// - host reads polling bit at the address being programmed
// - host polls erase status inside a sector chosen for erase
// - host re-reads polling bit after seeing timeout flag set
// - host reads status twice, equal toggle bit means finished
// - toggling with timeout flag set: recheck, still toggling is failure
// - host resuming status checks restarts whole polling sequence
// - host issues reset after failure and waits reset recovery time
`default_nettype none
module fws_host #(
    parameter int AW     = 22,
    parameter int TOR_NS = 20000
) (
    input  wire logic                      core_clk,
    input  wire logic                      rstn,
    input  wire logic                      ce,
    input  wire logic [fws_pkg::APB_AW-1:0] paddr,
    input  wire logic                      psel,
    input  wire logic                      penable,
    input  wire logic                      pwrite,
    input  wire logic [31:0]               pwdata,
    output logic      [31:0]               prdata,
    output logic                           pready,
    output logic                           pslverr,
    output logic      [AW-1:0]             flashAddr,
    output logic      [fws_pkg::DQ_W-1:0]  flashDqOut,
    output logic                           flashDqOeN,
    input  wire logic [fws_pkg::DQ_W-1:0]  flashDqIn,
    output logic                           flashCeN,
    output logic                           flashOeN,
    output logic                           flashWeN,
    input  wire logic                      readyBusy
);
    localparam logic [15:0] TOR_CYC = 16'((TOR_NS + fws_pkg::CLK_NS - 1) / fws_pkg::CLK_NS);

    typedef struct packed {
        fws_pkg::fws_state_t      state;
        logic [15:0]              cnt;
        fws_pkg::fws_op_t         op;
        logic [31:0]              addr;
        logic [fws_pkg::DQ_W-1:0] data;
        logic [fws_pkg::DQ_W-1:0] smp;
        logic [fws_pkg::DQ_W-1:0] prev;
        logic [fws_pkg::DQ_W-1:0] rdata;
        logic [fws_pkg::DQ_W-1:0] dqOut;
        logic                     busy;
        logic                     done;
        logic                     fail;
        logic                     havePrev;
        logic                     recheck;
        logic                     finalRd;
        logic                     tog;
        logic                     stog;
        logic                     tmo;
        logic                     ceN;
        logic                     oeN;
        logic                     weN;
        logic                     dqOeN;
        logic [31:0]              prdata;
    } fws_ctl_t;

    fws_ctl_t                 r;
    fws_ctl_t                 next_r;
    logic [fws_pkg::DQ_W:0]   syncIn;
    logic [fws_pkg::DQ_W:0]   syncOut;
    logic [fws_pkg::DQ_W-1:0] dqSync;
    logic                     rdySync;
    logic                     access;

    assign syncIn = {readyBusy, flashDqIn};

    fws_sync #(
        .W (fws_pkg::DQ_W + 1)
    ) u_sync (
        .core_clk (core_clk),
        .rstn     (rstn),
        .ce       (ce),
        .d        (syncIn),
        .q        (syncOut)
    );

    assign dqSync  = syncOut[fws_pkg::DQ_W-1:0];
    assign rdySync = syncOut[fws_pkg::DQ_W];

    function automatic logic mapped(input logic [fws_pkg::APB_AW-1:0] a);
        mapped = (a == fws_pkg::OFF_CTRL) || (a == fws_pkg::OFF_ADDR) ||
                 (a == fws_pkg::OFF_DATA) || (a == fws_pkg::OFF_STAT) ||
                 (a == fws_pkg::OFF_RDATA);
    endfunction

    function automatic logic [31:0] readMux(input logic [fws_pkg::APB_AW-1:0] a,
                                            input fws_ctl_t s,
                                            input logic rdy);
        logic [31:0] v;
        v = '0;
        case (a)
            fws_pkg::OFF_CTRL: begin
                v[fws_pkg::CTRL_OP_HI:fws_pkg::CTRL_OP_LO] = s.op;
            end
            fws_pkg::OFF_ADDR: begin
                v = s.addr;
            end
            fws_pkg::OFF_DATA: begin
                v[fws_pkg::DQ_W-1:0] = s.data;
            end
            fws_pkg::OFF_STAT: begin
                v[fws_pkg::STAT_BUSY] = s.busy;
                v[fws_pkg::STAT_DONE] = s.done;
                v[fws_pkg::STAT_FAIL] = s.fail;
                v[fws_pkg::STAT_RDY]  = rdy;
                v[fws_pkg::STAT_TOG]  = s.tog;
                v[fws_pkg::STAT_STOG] = s.stog;
                v[fws_pkg::STAT_TMO]  = s.tmo;
            end
            fws_pkg::OFF_RDATA: begin
                v[fws_pkg::DQ_W-1:0] = s.rdata;
            end
            default: begin
                v = '0;
            end
        endcase
        readMux = v;
    endfunction

    // access phase completes in its first cycle unless the clock enable is low
    assign access  = psel && penable && ce;
    assign pready  = access;
    assign pslverr = access && !mapped(paddr);

    always_comb begin
        next_r = r;
        if (psel && !penable && !pwrite) begin
            next_r.prdata = readMux(paddr, r, rdySync);
        end
        if (psel && penable && pwrite) begin
            case (paddr)
                fws_pkg::OFF_CTRL: begin
                    // a start while busy is dropped, so a running poll is never disturbed
                    if (pwdata[fws_pkg::CTRL_START] && !r.busy) begin
                        next_r.op       = fws_pkg::fws_op_t'(
                                          pwdata[fws_pkg::CTRL_OP_HI:fws_pkg::CTRL_OP_LO]);
                        next_r.busy     = 1'b1;
                        next_r.done     = 1'b0;
                        next_r.fail     = 1'b0;
                        next_r.havePrev = 1'b0;
                        next_r.recheck  = 1'b0;
                        next_r.finalRd  = 1'b0;
                        next_r.tmo      = 1'b0;
                        next_r.state    = fws_pkg::ST_START;
                    end
                end
                fws_pkg::OFF_ADDR: begin
                    if (!r.busy) begin
                        next_r.addr = pwdata;
                    end
                end
                fws_pkg::OFF_DATA: begin
                    if (!r.busy) begin
                        next_r.data = pwdata[fws_pkg::DQ_W-1:0];
                    end
                end
                fws_pkg::OFF_STAT: begin
                    if (pwdata[fws_pkg::STAT_DONE]) begin
                        next_r.done = 1'b0;
                    end
                    if (pwdata[fws_pkg::STAT_FAIL] && !r.busy) begin
                        next_r.fail = 1'b0;
                    end
                end
                default: begin
                end
            endcase
        end
        // the sequencer runs after the bus so a hardware set wins over a clear
        case (r.state)
            fws_pkg::ST_IDLE: begin
            end
            fws_pkg::ST_START: begin
                if (r.op == fws_pkg::OP_WRITE || r.op == fws_pkg::OP_RESET) begin
                    next_r.dqOut = (r.op == fws_pkg::OP_RESET) ? fws_pkg::RESET_CMD : r.data;
                    next_r.ceN   = 1'b0;
                    next_r.weN   = 1'b0;
                    next_r.dqOeN = 1'b0;
                    next_r.cnt   = fws_pkg::WP_CYC - 16'h0001;
                    next_r.state = fws_pkg::ST_WRACT;
                end else begin
                    // always at the programmed or erasing address held in addr
                    next_r.ceN   = 1'b0;
                    next_r.oeN   = 1'b0;
                    next_r.cnt   = fws_pkg::ACC_CYC - 16'h0001;
                    next_r.state = fws_pkg::ST_RDACT;
                end
            end
            fws_pkg::ST_WRACT: begin
                if (r.cnt != 16'h0000) begin
                    next_r.cnt = r.cnt - 16'h0001;
                end else begin
                    next_r.weN   = 1'b1;
                    next_r.ceN   = 1'b1;
                    next_r.cnt   = fws_pkg::GAP_CYC - 16'h0001;
                    next_r.state = fws_pkg::ST_WRGAP;
                end
            end
            fws_pkg::ST_WRGAP: begin
                if (r.cnt != 16'h0000) begin
                    next_r.cnt = r.cnt - 16'h0001;
                end else begin
                    next_r.dqOeN = 1'b1;
                    if (r.op == fws_pkg::OP_RESET) begin
                        next_r.cnt   = TOR_CYC - 16'h0001;
                        next_r.state = fws_pkg::ST_TOR;
                    end else begin
                        next_r.done  = 1'b1;
                        next_r.busy  = 1'b0;
                        next_r.state = fws_pkg::ST_IDLE;
                    end
                end
            end
            fws_pkg::ST_TOR: begin
                if (r.cnt != 16'h0000) begin
                    next_r.cnt = r.cnt - 16'h0001;
                end else begin
                    next_r.done  = 1'b1;
                    next_r.busy  = 1'b0;
                    next_r.state = fws_pkg::ST_IDLE;
                end
            end
            fws_pkg::ST_RDACT: begin
                if (r.cnt != 16'h0000) begin
                    next_r.cnt = r.cnt - 16'h0001;
                end else begin
                    // each read ends with both strobes high so the toggle bits advance
                    next_r.smp   = dqSync;
                    next_r.ceN   = 1'b1;
                    next_r.oeN   = 1'b1;
                    next_r.cnt   = fws_pkg::GAP_CYC - 16'h0001;
                    next_r.state = fws_pkg::ST_RDGAP;
                end
            end
            fws_pkg::ST_RDGAP: begin
                if (r.cnt != 16'h0000) begin
                    next_r.cnt = r.cnt - 16'h0001;
                end else begin
                    next_r.state = fws_pkg::ST_EVAL;
                end
            end
            fws_pkg::ST_EVAL: begin
                next_r.state = fws_pkg::ST_START;
                // the extra read after completion is array data, not a timeout flag
                if (!r.finalRd) begin
                    next_r.tmo = r.smp[fws_pkg::TMO_BIT];
                end
                if (r.finalRd) begin
                    // one more read after completion, since bit 7 may settle first
                    next_r.rdata = r.smp;
                    next_r.done  = 1'b1;
                    next_r.busy  = 1'b0;
                    next_r.state = fws_pkg::ST_IDLE;
                end else if (r.op == fws_pkg::OP_DPOLL) begin
                    if (r.smp[fws_pkg::POLL_BIT] == r.data[fws_pkg::POLL_BIT]) begin
                        next_r.finalRd = 1'b1;
                    end else if (r.recheck) begin
                        next_r.fail = 1'b1;
                        next_r.op   = fws_pkg::OP_RESET;
                    end else if (r.smp[fws_pkg::TMO_BIT]) begin
                        next_r.recheck = 1'b1;
                    end
                end else begin
                    next_r.prev     = r.smp;
                    next_r.havePrev = 1'b1;
                    if (r.havePrev) begin
                        next_r.tog  = r.smp[fws_pkg::TOG_BIT] ^ r.prev[fws_pkg::TOG_BIT];
                        next_r.stog = r.smp[fws_pkg::STOG_BIT] ^ r.prev[fws_pkg::STOG_BIT];
                        if (r.smp[fws_pkg::TOG_BIT] == r.prev[fws_pkg::TOG_BIT]) begin
                            next_r.finalRd = 1'b1;
                        end else if (r.recheck) begin
                            next_r.fail = 1'b1;
                            next_r.op   = fws_pkg::OP_RESET;
                        end else if (r.smp[fws_pkg::TMO_BIT]) begin
                            next_r.recheck = 1'b1;
                        end
                    end
                end
            end
            default: begin
                next_r.state = fws_pkg::ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            r       <= '0;
            r.state <= fws_pkg::ST_IDLE;
            r.op    <= fws_pkg::OP_WRITE;
            r.ceN   <= 1'b1;
            r.oeN   <= 1'b1;
            r.weN   <= 1'b1;
            r.dqOeN <= 1'b1;
        end else if (ce) begin
            r <= next_r;
        end
    end

    assign prdata     = r.prdata;
    assign flashAddr  = r.addr[AW-1:0];
    assign flashDqOut = r.dqOut;
    assign flashDqOeN = r.dqOeN;
    assign flashCeN   = r.ceN;
    assign flashOeN   = r.oeN;
    assign flashWeN   = r.weN;
endmodule
`default_nettype wire

// ---- bench/fws_host_props.sv ----
`default_nettype none
module fws_host_props #(
    parameter int AW = 22
) (
    input wire logic                       core_clk,
    input wire logic                       rstn,
    input wire logic                       ce,
    input wire logic [fws_pkg::APB_AW-1:0] paddr,
    input wire logic                       psel,
    input wire logic                       penable,
    input wire logic                       pwrite,
    input wire logic [31:0]                pwdata,
    input wire logic [31:0]                prdata,
    input wire logic                       pready,
    input wire logic                       pslverr,
    input wire logic [AW-1:0]              flashAddr,
    input wire logic [fws_pkg::DQ_W-1:0]   flashDqOut,
    input wire logic                       flashDqOeN,
    input wire logic [fws_pkg::DQ_W-1:0]   flashDqIn,
    input wire logic                       flashCeN,
    input wire logic                       flashOeN,
    input wire logic                       flashWeN,
    input wire logic                       readyBusy
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (!rstn);
    // status is only valid at the programmed address, so it must not move mid-read
    AST_RD_ADDR_STABLE: assert property (!flashOeN && $past(!flashOeN) |-> $stable(flashAddr))
        else $error("flash address moved during a read");
    AST_RD_HOLD: assert property ($fell(flashOeN) |-> !flashOeN [*8])
        else $error("read strobe released too early");
    AST_RD_GAP: assert property ($rose(flashOeN) |-> flashOeN [*4])
        else $error("reads not separated");
    AST_RD_BUS: assert property (!flashOeN |-> !flashCeN && flashDqOeN && flashWeN)
        else $error("read without select or with bus driven");
    AST_WR_DRIVE: assert property (!flashWeN |-> !flashDqOeN && !flashCeN)
        else $error("write pulse without data driven");
    AST_WR_LEN: assert property ($fell(flashWeN) |-> !flashWeN [*7] ##1 flashWeN)
        else $error("write pulse length wrong");
    AST_TOR_WAIT: assert property ($rose(flashWeN) && flashDqOut == fws_pkg::RESET_CMD
        |-> flashOeN [*8])
        else $error("read too soon after reset command");
    AST_SLVERR: assert property (pready && paddr > fws_pkg::OFF_RDATA |-> pslverr)
        else $error("unmapped access not refused");
    COV_RESET_CMD: cover property ($rose(flashWeN) && flashDqOut == fws_pkg::RESET_CMD);
    COV_READ: cover property ($fell(flashOeN));
    COV_SLVERR: cover property (pslverr);
endmodule

bind fws_host fws_host_props #(
    .AW (AW)
) fws_host_props_inst (
    .core_clk   (core_clk),
    .rstn       (rstn),
    .ce         (ce),
    .paddr      (paddr),
    .psel       (psel),
    .penable    (penable),
    .pwrite     (pwrite),
    .pwdata     (pwdata),
    .prdata     (prdata),
    .pready     (pready),
    .pslverr    (pslverr),
    .flashAddr  (flashAddr),
    .flashDqOut (flashDqOut),
    .flashDqOeN (flashDqOeN),
    .flashDqIn  (flashDqIn),
    .flashCeN   (flashCeN),
    .flashOeN   (flashOeN),
    .flashWeN   (flashWeN),
    .readyBusy  (readyBusy)
);
`default_nettype wire

// ---- bench/fws_flash_model.sv ----
`default_nettype none
module fws_flash_model #(
    parameter int AW = 22
) (
    input wire logic [AW-1:0] flashAddr,
    input wire logic [15:0]   flashDqOut,
    input wire logic          flashDqOeN,
    input wire logic          flashCeN,
    input wire logic          flashOeN,
    input wire logic          flashWeN,
    input wire logic          failMode,
    input wire logic [3:0]    busyReads,
    output logic     [15:0]   flashDqIn,
    output logic              readyBusy
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [15:0] mem [16];
    logic [15:0] pdata = 16'h0000;
    logic [15:0] last = 16'h0000;
    logic [15:0] rdVal;
    logic [3:0]  left = 4'h0;
    logic [3:0]  pAddr = 4'h0;
    logic        busy = 1'b0;
    logic        tog = 1'b0;
    logic        tmo = 1'b0;
    logic        fresh = 1'b0;
    wire logic   rdN = flashOeN | flashCeN;
    initial for (int i = 0; i < 16; i++) mem[i] = 16'hffff;
    // a write pulse rising edge starts the operation; status valid from here on
    always @(posedge flashWeN) begin
        // strobes leave unknown at reset, so only a pulse with data driven counts
        if (flashDqOeN !== 1'b0) begin
        end else if (flashDqOut == fws_pkg::RESET_CMD) begin
            busy = 1'b0;
            tmo = 1'b0;
            fresh = 1'b0;
        end else if (!busy) begin
            fresh = 1'b0;
            pdata = flashDqOut;
            pAddr = flashAddr[3:0];
            left = busyReads;
            busy = 1'b1;
        end
    end
    // bit 2 stays 0: only programs are modelled, the sector toggle is erase-only
    // right after completion bits 15:7 are true data while bits 6 and 5 still show status
    assign rdVal = busy  ? {8'h00, ~pdata[7], tog, tmo, 5'h00} :
                   fresh ? {pdata[15:7], tog, tmo, 5'h00} : mem[flashAddr[3:0]];
    always @(posedge rdN) begin
        last = rdVal;
        if (busy) begin
            tog = ~tog;
            if (left != 4'h0) begin
                left = left - 4'h1;
            end else if (failMode) begin
                tmo = 1'b1;
            end else begin
                busy = 1'b0;
                fresh = 1'b1;
                mem[pAddr] = pdata;
            end
        end else begin
            fresh = 1'b0;
        end
    end
    // undriven bus shows the inverse of the last read, never a stale copy
    assign flashDqIn = !flashDqOeN ? flashDqOut : (!rdN ? rdVal : ~last);
    assign readyBusy = !busy;
endmodule
`default_nettype wire

// ---- bench/test_fws_host.sv ----
`default_nettype none
module test_fws_host;
    timeunit 1ns;
    timeprecision 1ps;
    logic        core_clk = 1'b0;
    logic        rstn = 1'b0;
    logic        ce = 1'b1;
    logic [7:0]  paddr = 8'h00;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic [21:0] flashAddr;
    logic [15:0] flashDqOut;
    logic        flashDqOeN;
    logic [15:0] flashDqIn;
    logic        flashCeN;
    logic        flashOeN;
    logic        flashWeN;
    logic        readyBusy;
    logic        failMode = 1'b0;
    logic [3:0]  busyReads = 4'h3;
    logic [31:0] expD[$];
    logic [31:0] expM[$];
    logic        expE[$];
    logic [31:0] seed = 32'hbd7f;
    logic [31:0] rd;
    logic [15:0] data;
    int          errors = 0;
    int          cmpCount = 0;

    always #2.5 core_clk = ~core_clk;

    fws_host #(
        .AW     (22),
        .TOR_NS (100)
    ) fws_host_inst (
        .core_clk   (core_clk),
        .rstn       (rstn),
        .ce         (ce),
        .paddr      (paddr),
        .psel       (psel),
        .penable    (penable),
        .pwrite     (pwrite),
        .pwdata     (pwdata),
        .prdata     (prdata),
        .pready     (pready),
        .pslverr    (pslverr),
        .flashAddr  (flashAddr),
        .flashDqOut (flashDqOut),
        .flashDqOeN (flashDqOeN),
        .flashDqIn  (flashDqIn),
        .flashCeN   (flashCeN),
        .flashOeN   (flashOeN),
        .flashWeN   (flashWeN),
        .readyBusy  (readyBusy)
    );

    fws_flash_model #(
        .AW (22)
    ) fws_flash_model_inst (
        .flashAddr  (flashAddr),
        .flashDqOut (flashDqOut),
        .flashDqOeN (flashDqOeN),
        .flashCeN   (flashCeN),
        .flashOeN   (flashOeN),
        .flashWeN   (flashWeN),
        .failMode   (failMode),
        .busyReads  (busyReads),
        .flashDqIn  (flashDqIn),
        .readyBusy  (readyBusy)
    );

    function automatic logic [31:0] xs(input logic [31:0] s);
        s = s ^ (s << 13);
        s = s ^ (s >> 17);
        s = s ^ (s << 5);
        return s;
    endfunction

    task automatic end_of_test();
        $display("counts: %0d compares, %0d errors", cmpCount, errors);
        if (errors == 0 && cmpCount > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask

    task automatic cmp_apb(input logic [31:0] d, input logic e);
        logic [31:0] ed;
        logic [31:0] em;
        logic        ee;
        ed = expD.pop_front();
        em = expM.pop_front();
        ee = expE.pop_front();
        cmpCount++;
        if ((d & em) !== (ed & em) || e !== ee) begin
            errors++;
            $display("mismatch at %0t: got %h/%b want %h/%b", $time, d & em, e, ed & em, ee);
        end
    endtask

    // msk zero with err clear means a plain access with no expectation noted
    task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] wd,
                       input logic [31:0] ex, input logic [31:0] msk, input logic err);
        @(posedge core_clk);
        paddr <= a;
        pwrite <= w;
        pwdata <= wd;
        psel <= 1'b1;
        penable <= 1'b0;
        @(posedge core_clk);
        penable <= 1'b1;
        if (msk != 0 || err) begin
            expD.push_back(ex);
            expM.push_back(msk);
            expE.push_back(err);
        end
        @(posedge core_clk);
        while (pready !== 1'b1) @(posedge core_clk);
        rd = prdata;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    always @(posedge core_clk) begin
        if (psel && penable && pready === 1'b1 && expE.size() > 0) cmp_apb(prdata, pslverr);
    end

    task automatic wait_done();
        int n;
        n = 0;
        rd = 32'h0;
        while (rd[fws_pkg::STAT_DONE] !== 1'b1 && n < 3000) begin
            apb(fws_pkg::OFF_STAT, 1'b0, 32'h0, 32'h0, 32'h0, 1'b0);
            n++;
        end
        if (n >= 3000) begin
            errors++;
            $display("mismatch at %0t: operation never done", $time);
        end
    endtask

    task automatic start_op(input logic [1:0] op);
        apb(fws_pkg::OFF_CTRL, 1'b1, {29'h0, op, 1'b1}, 32'h0, 32'h0, 1'b0);
        wait_done();
    endtask

    initial begin
        repeat (10) @(posedge core_clk);
        rstn <= 1'b1;
        repeat (8) @(posedge core_clk);
        apb(fws_pkg::OFF_STAT, 1'b0, 32'h0, 32'h8, 32'h4f, 1'b0);
        apb(fws_pkg::OFF_CTRL, 1'b0, 32'h0, 32'h0, 32'h6, 1'b0);
        apb(8'h14, 1'b0, 32'h0, 32'h0, 32'hffffffff, 1'b1);
        apb(8'h20, 1'b1, 32'h5, 32'h0, 32'h0, 1'b1);
        $display("test reset_and_map done");
        for (int i = 0; i < 4; i++) begin
            seed = xs(seed);
            // array data keeps bit 5 clear, so a completed read never looks like a timeout
            data = seed[15:0] & 16'hffdf;
            if (data == fws_pkg::RESET_CMD) data = data ^ 16'h0001;
            failMode <= i[1];
            busyReads <= seed[19:16] & 4'h7;
            apb(fws_pkg::OFF_ADDR, 1'b1, {28'h0, seed[23:20]}, 32'h0, 32'h0, 1'b0);
            apb(fws_pkg::OFF_DATA, 1'b1, {16'h0, data}, 32'h0, 32'h0, 1'b0);
            start_op(2'h0);
            apb(fws_pkg::OFF_STAT, 1'b0, 32'h0, 32'h2, 32'hb, 1'b0);
            start_op(i[0] ? 2'h2 : 2'h1);
            if (i[1]) begin
                apb(fws_pkg::OFF_STAT, 1'b0, 32'h0, 32'h4e, 32'h4f, 1'b0);
                apb(fws_pkg::OFF_STAT, 1'b1, 32'h4, 32'h0, 32'h0, 1'b0);
                apb(fws_pkg::OFF_STAT, 1'b0, 32'h0, 32'h0, 32'h5, 1'b0);
            end else begin
                apb(fws_pkg::OFF_STAT, 1'b0, 32'h0, 32'h0a, 32'h5f, 1'b0);
                apb(fws_pkg::OFF_RDATA, 1'b0, 32'h0, {16'h0, data}, 32'hffff, 1'b0);
            end
            $display("test poll %0d done", i);
        end
        end_of_test();
    end

    initial begin
        repeat (60000) @(posedge core_clk);
        errors++;
        $display("mismatch at %0t: watchdog expired", $time);
        end_of_test();
    end
endmodule
`default_nettype wire
